//--- rtl/asc_pkg.sv
package asc_pkg;

  // ****************************************************************
  // Widths and serial framing
  // ****************************************************************
  localparam int DATA_W = 24;
  localparam int CW = 24;
  localparam int CMD_BITS = 8;
  localparam int WEN_BIT = 7;
  localparam int RW_BIT = 6;
  localparam int RS_HI = 5;
  localparam int RS_LO = 3;
  localparam int CREAD_BIT = 2;
  localparam logic [7:0] CREAD_EXIT = 8'h58;
  localparam logic [5:0] LEN_STATUS = 6'h08;
  localparam logic [5:0] LEN_WORD = 6'h18;
  localparam logic [5:0] LEN_APPEND = 6'h20;
  localparam logic [5:0] RESET_ONES = 6'h28;

  // ****************************************************************
  // Register select codes and field positions
  // ****************************************************************
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_CONFIG = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h3;
  localparam int MD_HI = 23;
  localparam int MD_LO = 21;
  localparam int APPEND_BIT = 20;
  localparam int ZERO_LAT_BIT = 11;
  localparam int FS_HI = 9;
  localparam int FS_LO = 0;
  localparam int CH_HI = 15;
  localparam int CH_LO = 8;
  localparam logic [23:0] MODE_RST = 24'h000060;
  localparam logic [23:0] CONFIG_RST = 24'h000100;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SETTLE_PERIODS = 4;
  localparam int FS_UNIT_CYC = 1024;
  localparam int OSC_START_US = 1000;
  localparam int CLK_KHZ = 25000;
  localparam int OSC_START_CYC = (OSC_START_US * CLK_KHZ + 999) / 1000;

  typedef enum logic [2:0] {
    MD_CONT = 3'b000,
    MD_SINGLE = 3'b001,
    MD_IDLE = 3'b010,
    MD_PDOWN = 3'b011
  } asc_md_e;

  typedef enum logic [1:0] {
    SP_CMD = 2'b00,
    SP_WR = 2'b01,
    SP_RD = 2'b10
  } asc_sp_e;

  typedef enum logic [1:0] {
    SQ_OFF = 2'b00,
    SQ_OSC = 2'b01,
    SQ_CONV = 2'b10
  } asc_sq_e;

endpackage

//--- rtl/asc_conv_if.sv
interface asc_conv_if;
  import asc_pkg::*;
  logic start;
  logic stop;
  logic zero_lat;
  logic [CW-1:0] period;
  logic pre;
  logic done;
  modport seq (output start, stop, zero_lat, period, input pre, done);
  modport tmr (input start, stop, zero_lat, period, output pre, done);
endinterface

//--- rtl/asc_sync.sv
module asc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk, // Sampling clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised inputs
);
  logic [W-1:0] meta_q;
  logic [W-1:0] q_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= RST;
      q_q <= RST;
    end else begin
      meta_q <= d;
      q_q <= meta_q;
    end
  end

  assign q = q_q;
endmodule

//--- rtl/asc_settle.sv
module asc_settle import asc_pkg::*; (
  input wire logic clk, // Master clock
  input wire logic rstn, // Synchronous reset, active low
  asc_conv_if.tmr cv // Start, stop and result timing
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] settle;
  logic run_q;
  logic run_d;
  logic pre_q;
  logic pre_d;
  logic done_q;
  logic done_d;

  always_comb begin
    settle = CW'(cv.period * SETTLE_PERIODS);
    cnt_d = cnt_q;
    run_d = run_q;
    pre_d = 1'b0;
    done_d = 1'b0;
    if (cv.stop) begin
      run_d = 1'b0;
    end else if (cv.start) begin
      run_d = 1'b1;
      cnt_d = settle;
    end else if (run_q) begin
      if (cnt_q == CW'(2)) begin
        pre_d = 1'b1;
      end
      if (cnt_q <= CW'(1)) begin
        done_d = 1'b1;
        cnt_d = cv.zero_lat ? settle : cv.period;
      end else begin
        cnt_d = cnt_q - CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      pre_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      pre_q <= pre_d;
      done_q <= done_d;
    end
  end

  assign cv.pre = pre_q;
  assign cv.done = done_q;

  chk_zl_reload: assert property (
    @(posedge clk) disable iff (!rstn)
    done_q && cv.zero_lat && !$past(cv.start) && !$past(cv.stop)
    |-> cnt_q == CW'(cv.period * SETTLE_PERIODS))
    else $error("zero latency result period is not one settling time");

  chk_pre_done: assert property (
    @(posedge clk) disable iff (!rstn)
    pre_q && !cv.start && !cv.stop |=> done_q)
    else $error("ready pre-warning not followed by a result");
endmodule

//--- rtl/asc_ctrl.sv
module asc_ctrl import asc_pkg::*; #(
  parameter int OSC_CYC = OSC_START_CYC,
  parameter int FS_UNIT = FS_UNIT_CYC
) (
  input wire logic clk, // Master clock, 25 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic cs_n, // Chip select pin, active low
  input wire logic sclk, // Serial clock pin from the host
  input wire logic din, // Serial data input pin
  input wire logic [DATA_W-1:0] filter_result, // Filter output word
  output logic dout_rdy, // Data-out/ready pin level
  output logic dout_rdy_oe, // Data-out/ready pin drive enable
  output logic mod_reset, // One-cycle modulator and filter reset
  output logic powered_up, // Converter powered and clocked
  output logic [2:0] conv_channel // Channel being converted
);

  // ****************************************************************
  // Pin sampling and settling timer
  // ****************************************************************
  logic [2:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic din_s;

  // Reset to idle pin levels so no false serial clock edge follows reset
  asc_sync #(.W(3), .RST(3'h6)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({cs_n, sclk, din}),
    .q(pins_s)
  );

  assign cs_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[0];

  asc_conv_if cv();

  asc_settle u_settle (
    .clk(clk),
    .rstn(rstn),
    .cv(cv)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [3:0] next_en(input logic [7:0] en,
                                         input logic [2:0] cur);
    logic [3:0] r;
    logic [2:0] idx;
    r = {1'b1, cur};
    for (int i = 7; i >= 1; i--) begin
      idx = cur + 3'(i);
      if (en[idx]) begin
        r = {idx < cur, idx};
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] reg_len(input logic [2:0] rs,
                                         input logic sta);
    if (rs == REG_STATUS) begin
      return LEN_STATUS;
    end else if (rs == REG_DATA) begin
      return sta ? LEN_APPEND : LEN_WORD;
    end else begin
      return LEN_WORD;
    end
  endfunction

  function automatic logic [31:0] reg_image(input logic [2:0] rs,
                                            input logic [23:0] mode,
                                            input logic [23:0] cfg,
                                            input logic [23:0] data,
                                            input logic [7:0] stat);
    if (rs == REG_STATUS) begin
      return {stat, 24'h000000};
    end else if (rs == REG_MODE) begin
      return {mode, 8'h00};
    end else if (rs == REG_CONFIG) begin
      return {cfg, 8'h00};
    end else if (rs == REG_DATA) begin
      return {data, mode[APPEND_BIT] ? stat : 8'h00};
    end else begin
      return 32'h00000000;
    end
  endfunction

  // ****************************************************************
  // Serial interface and register file
  // ****************************************************************
  asc_sp_e sp_q, sp_d;
  logic [5:0] bitcnt_q, bitcnt_d;
  logic [5:0] len_q, len_d;
  logic [5:0] ones_q, ones_d;
  logic [2:0] rs_q, rs_d;
  logic [23:0] sh_in_q, sh_in_d;
  logic [31:0] sh_out_q, sh_out_d;
  logic [23:0] mode_q, mode_d;
  logic [23:0] config_q, config_d;
  logic cread_q, cread_d;
  logic sclk_q;
  logic rdy_prev_q;
  logic rise, active, rdy_fell, rd_busy;
  logic wr_mode, wr_cfg, rd_done, soft_rst;
  logic [7:0] cmd_byte;
  logic [23:0] word_in;
  logic [7:0] status;
  logic rdy_n_q;
  logic [3:0] stat_ch_q;
  logic [DATA_W-1:0] data_q;
  logic pdn_req_q;

  assign rise = sclk_s && !sclk_q;
  assign active = !cs_s;
  assign rdy_fell = rdy_prev_q && !rdy_n_q;
  assign rd_busy = (sp_q == SP_RD) && (rs_q == REG_DATA);
  assign cmd_byte = {sh_in_q[6:0], din_s};
  assign word_in = {sh_in_q[22:0], din_s};
  assign status = {rdy_n_q, 3'h0, stat_ch_q};

  always_comb begin
    sp_d = sp_q;
    bitcnt_d = bitcnt_q;
    len_d = len_q;
    ones_d = ones_q;
    rs_d = rs_q;
    sh_in_d = sh_in_q;
    sh_out_d = sh_out_q;
    mode_d = mode_q;
    config_d = config_q;
    cread_d = cread_q;
    wr_mode = 1'b0;
    wr_cfg = 1'b0;
    rd_done = 1'b0;
    soft_rst = 1'b0;
    if (pdn_req_q) begin
      mode_d[MD_HI:MD_LO] = MD_PDOWN;
    end
    if (!active) begin
      sp_d = SP_CMD;
      bitcnt_d = 6'h00;
    end else if (cread_q && sp_q == SP_CMD && bitcnt_q == 6'h00 &&
                 rdy_fell) begin
      sp_d = SP_RD;
      rs_d = REG_DATA;
      len_d = reg_len(REG_DATA, mode_q[APPEND_BIT]);
      sh_out_d = reg_image(REG_DATA, mode_q, config_q, data_q, status);
    end else if (rise) begin
      sh_in_d = word_in;
      bitcnt_d = bitcnt_q + 6'h01;
      ones_d = din_s ? ones_q + 6'h01 : 6'h00;
      case (sp_q)
        SP_CMD: begin
          if (bitcnt_q == 6'(CMD_BITS - 1)) begin
            bitcnt_d = 6'h00;
            if (cread_q) begin
              if (cmd_byte == CREAD_EXIT) begin
                cread_d = 1'b0;
              end
            end else if (!cmd_byte[WEN_BIT]) begin
              rs_d = cmd_byte[RS_HI:RS_LO];
              len_d = reg_len(cmd_byte[RS_HI:RS_LO], mode_q[APPEND_BIT]);
              if (!cmd_byte[RW_BIT]) begin
                sp_d = SP_WR;
              end else if (cmd_byte[CREAD_BIT] &&
                           cmd_byte[RS_HI:RS_LO] == REG_DATA) begin
                cread_d = 1'b1;
              end else begin
                sp_d = SP_RD;
                sh_out_d = reg_image(cmd_byte[RS_HI:RS_LO], mode_q,
                                     config_q, data_q, status);
              end
            end
          end
        end
        SP_WR: begin
          if (bitcnt_q == len_q - 6'h01) begin
            sp_d = SP_CMD;
            bitcnt_d = 6'h00;
            if (rs_q == REG_MODE) begin
              mode_d = word_in;
              wr_mode = 1'b1;
            end else if (rs_q == REG_CONFIG) begin
              config_d = word_in;
              wr_cfg = 1'b1;
            end
          end
        end
        SP_RD: begin
          sh_out_d = {sh_out_q[30:0], 1'b0};
          if (bitcnt_q == len_q - 6'h01) begin
            sp_d = SP_CMD;
            bitcnt_d = 6'h00;
            rd_done = (rs_q == REG_DATA);
          end
        end
        default: begin
          sp_d = SP_CMD;
        end
      endcase
      if (din_s && ones_q == RESET_ONES - 6'h01) begin
        soft_rst = 1'b1;
        sp_d = SP_CMD;
        bitcnt_d = 6'h00;
        ones_d = 6'h00;
        cread_d = 1'b0;
        mode_d = MODE_RST;
        config_d = CONFIG_RST;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sp_q <= SP_CMD;
      bitcnt_q <= 6'h00;
      len_q <= LEN_WORD;
      ones_q <= 6'h00;
      rs_q <= REG_STATUS;
      sh_in_q <= 24'h000000;
      sh_out_q <= 32'h00000000;
      mode_q <= MODE_RST;
      config_q <= CONFIG_RST;
      cread_q <= 1'b0;
      sclk_q <= 1'b1;
      rdy_prev_q <= 1'b1;
    end else begin
      sp_q <= sp_d;
      bitcnt_q <= bitcnt_d;
      len_q <= len_d;
      ones_q <= ones_d;
      rs_q <= rs_d;
      sh_in_q <= sh_in_d;
      sh_out_q <= sh_out_d;
      mode_q <= mode_d;
      config_q <= config_d;
      cread_q <= cread_d;
      sclk_q <= sclk_s;
      rdy_prev_q <= rdy_n_q;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  asc_sq_e sq_q, sq_d;
  asc_md_e md_new;
  logic [2:0] ch_q, ch_d;
  logic [CW-1:0] osc_q, osc_d;
  logic [3:0] stat_ch_d;
  logic [DATA_W-1:0] data_d;
  logic rdy_n_d, single_q, single_d, pdn_req_d;
  logic modrst_q, modrst_d, pwr_q, pwr_d, dout_q, dout_d, oe_q, oe_d;
  logic start_c, stop_c, restart;
  logic [3:0] first, nx;
  logic [9:0] fs;

  assign fs = mode_q[FS_HI:FS_LO];
  assign cv.period = CW'((fs == 10'h000 ? 10'h001 : fs) * FS_UNIT);
  assign cv.zero_lat = mode_q[ZERO_LAT_BIT];
  assign cv.start = start_c;
  assign cv.stop = stop_c;
  assign md_new = asc_md_e'(mode_d[MD_HI:MD_LO]);
  assign first = next_en(config_d[CH_HI:CH_LO], 3'h7);
  assign nx = next_en(config_q[CH_HI:CH_LO], ch_q);

  always_comb begin
    sq_d = sq_q;
    ch_d = ch_q;
    osc_d = osc_q;
    data_d = data_q;
    stat_ch_d = stat_ch_q;
    rdy_n_d = rdy_n_q;
    single_d = single_q;
    pdn_req_d = 1'b0;
    modrst_d = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    restart = 1'b0;
    if (rd_done) begin
      rdy_n_d = 1'b1;
    end
    case (sq_q)
      SQ_OSC: begin
        osc_d = osc_q + CW'(1);
        if (osc_q == CW'(OSC_CYC - 1)) begin
          restart = 1'b1;
        end
      end
      SQ_CONV: begin
        if (cv.pre && !rd_busy) begin
          rdy_n_d = 1'b1;
        end
        if (cv.done) begin
          if (!rd_busy) begin
            data_d = filter_result;
            stat_ch_d = {1'b0, ch_q};
            rdy_n_d = 1'b0;
          end
          if (single_q && nx[3]) begin
            sq_d = SQ_OFF;
            stop_c = 1'b1;
            pdn_req_d = 1'b1;
          end else if (nx[2:0] != ch_q) begin
            ch_d = nx[2:0];
            start_c = 1'b1;
            modrst_d = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
    if (wr_mode) begin
      restart = 1'b0;
      if (md_new == MD_CONT || md_new == MD_SINGLE) begin
        single_d = (md_new == MD_SINGLE);
        if (sq_q == SQ_OFF) begin
          sq_d = SQ_OSC;
          osc_d = '0;
          rdy_n_d = 1'b1;
        end else begin
          restart = 1'b1;
        end
      end else begin
        sq_d = SQ_OFF;
        stop_c = 1'b1;
      end
    end else if (wr_cfg && sq_q == SQ_CONV) begin
      restart = 1'b1;
    end
    if (restart) begin
      start_c = 1'b0;
      if (|config_d[CH_HI:CH_LO]) begin
        sq_d = SQ_CONV;
        ch_d = first[2:0];
        start_c = 1'b1;
        modrst_d = 1'b1;
        rdy_n_d = 1'b1;
      end else begin
        sq_d = SQ_OFF;
        stop_c = 1'b1;
      end
    end
    if (soft_rst) begin
      sq_d = SQ_OSC;
      osc_d = '0;
      ch_d = 3'h0;
      data_d = '0;
      stat_ch_d = 4'h0;
      rdy_n_d = 1'b1;
      single_d = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b1;
      modrst_d = 1'b0;
      pdn_req_d = 1'b0;
    end
    dout_d = (sp_d == SP_RD) ? sh_out_d[31] : rdy_n_d;
    oe_d = active;
    pwr_d = (sq_d != SQ_OFF);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sq_q <= SQ_OSC;
      ch_q <= 3'h0;
      osc_q <= '0;
      data_q <= '0;
      stat_ch_q <= 4'h0;
      rdy_n_q <= 1'b1;
      single_q <= 1'b0;
      pdn_req_q <= 1'b0;
      modrst_q <= 1'b0;
      pwr_q <= 1'b1;
      dout_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      sq_q <= sq_d;
      ch_q <= ch_d;
      osc_q <= osc_d;
      data_q <= data_d;
      stat_ch_q <= stat_ch_d;
      rdy_n_q <= rdy_n_d;
      single_q <= single_d;
      pdn_req_q <= pdn_req_d;
      modrst_q <= modrst_d;
      pwr_q <= pwr_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  assign dout_rdy = dout_q;
  assign dout_rdy_oe = oe_q;
  assign mod_reset = modrst_q;
  assign powered_up = pwr_q;
  assign conv_channel = ch_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_switch_reset: assert property (
    @(posedge clk) disable iff (!rstn)
    ch_q != $past(ch_q) && sq_q == SQ_CONV |-> modrst_q)
    else $error("channel changed without modulator reset");

  chk_rdy_cause: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(rdy_n_q) |-> $past(cv.done) && !$past(rd_busy))
    else $error("ready went low without a new result");

  chk_read_high: assert property (
    @(posedge clk) disable iff (!rstn)
    rd_done && !cv.done |=> rdy_n_q)
    else $error("ready not high after data read");

  chk_ones_reset: assert property (
    @(posedge clk) disable iff (!rstn)
    active && rise && din_s && ones_q == RESET_ONES - 6'h01
    |=> sp_q == SP_CMD && mode_q == MODE_RST && config_q == CONFIG_RST)
    else $error("run of ones did not reset the interface");

  chk_frame_cmd: assert property (
    @(posedge clk) disable iff (!rstn)
    cs_s |=> sp_q == SP_CMD && bitcnt_q == 6'h00)
    else $error("interface not awaiting a command after frame");

  chk_stat_chan: assert property (
    @(posedge clk) disable iff (!rstn)
    sq_q == SQ_CONV && cv.done && !rd_busy && !soft_rst
    |=> stat_ch_q == {1'b0, $past(ch_q)})
    else $error("status channel does not match result");

  chk_single_end: assert property (
    @(posedge clk) disable iff (!rstn)
    sq_q == SQ_CONV && single_q && cv.done && nx[3] && !wr_mode &&
    !soft_rst |=> sq_q == SQ_OFF ##1 mode_q[MD_HI:MD_LO] == MD_PDOWN)
    else $error("single scan did not power down");

  chk_append_len: assert property (
    @(posedge clk) disable iff (!rstn)
    sp_q == SP_RD && rs_q == REG_DATA
    |-> len_q == (mode_q[APPEND_BIT] ? LEN_APPEND : LEN_WORD))
    else $error("data read length ignores status append");

  chk_osc_wait: assert property (
    @(posedge clk) disable iff (!rstn)
    sq_q == SQ_OSC && osc_q != CW'(OSC_CYC - 1) && !wr_mode && !soft_rst
    |=> sq_q != SQ_CONV)
    else $error("conversion started before oscillator wait");
endmodule

//--- verif/asc_host.sv
// ****************************************************************
// Host serial port: frames, ready wait, bit clocking
// ****************************************************************
module asc_host (
  input wire logic clk, // Master clock
  input wire logic req, // Frame request
  input wire logic hold, // Keep chip select low after frame
  input wire logic wrdy, // Wait for ready low first
  input wire logic [5:0] nb, // Bit count
  input wire logic [39:0] tx, // Bits out, MSB first
  input wire logic dw, // Data-out/ready wire
  output logic cs_n, // Chip select, active low
  output logic sclk, // Serial clock
  output logic din, // Serial data out
  output logic done, // Frame finished
  output logic to, // Ready wait ran out
  output logic [39:0] rx // Bits sampled
);
  timeunit 1ns;
  timeprecision 100ps;
  int i;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
    done = 1'b0;
    to = 1'b0;
    rx = '0;
    forever begin
      @(posedge clk);
      if (req && !done) begin
        #7.3 cs_n = 1'b0;
        #200 i = 0;
        while (wrdy && dw !== 1'b0 && i < 9000) begin
          @(posedge clk);
          i++;
        end
        to = (i == 9000);
        rx = '0;
        for (i = int'(nb) - 1; i >= 0; i--) begin
          sclk = 1'b0;
          din = tx[i];
          #160 sclk = 1'b1;
          rx = {rx[38:0], dw};
          #160;
        end
        cs_n = !hold;
        din = !din;
        @(posedge clk) done <= 1'b1;
        while (req) @(posedge clk);
        done <= 1'b0;
      end
    end
  end
endmodule

//--- verif/asc_ctrl_test.sv
module asc_ctrl_test import asc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rstn, req, hold, wrdy, done, done_q, to, cs_n, sclk, din, dw;
  logic dout_rdy, dout_rdy_oe, mod_reset, powered_up, seq_on;
  logic dw_last = 1'b1;
  logic [5:0] nb;
  logic [39:0] tx, rx, m, e;
  logic [39:0] exp_q[$];
  logic [39:0] msk_q[$];
  logic [DATA_W-1:0] fr, f0;
  logic [2:0] conv_channel, ch_prev;
  logic [7:0] mask;
  logic [23:0] md_t[4];
  logic [23:0] cf_t[4];
  int per_t[4];
  int errors, tests_run, c, i;

  asc_ctrl #(.OSC_CYC(20), .FS_UNIT(4)) DUT (.clk(clk), .rstn(rstn),
    .cs_n(cs_n), .sclk(sclk), .din(din), .filter_result(fr),
    .dout_rdy(dout_rdy), .dout_rdy_oe(dout_rdy_oe),
    .mod_reset(mod_reset), .powered_up(powered_up),
    .conv_channel(conv_channel));
  asc_host host (.clk(clk), .req(req), .hold(hold), .wrdy(wrdy), .nb(nb),
    .tx(tx), .dw(dw), .cs_n(cs_n), .sclk(sclk), .din(din), .done(done),
    .to(to), .rx(rx));
  // Released line shows the inverse of the last driven level
  always @(posedge clk) begin
    if (dout_rdy_oe) dw_last <= dout_rdy;
  end
  assign dw = dout_rdy_oe ? dout_rdy : !dw_last;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [2:0] nxt(input logic [7:0] mk,
      input logic [2:0] cur);
    logic [2:0] k;
    k = cur;
    for (int j = 0; j < 8; j++) begin
      k = k + 3'h1;
      if (mk[k]) return k;
    end
    return cur;
  endfunction
  task automatic xfer(input logic h, input logic w, input logic [5:0] n,
      input logic [39:0] d, input logic [39:0] mk, input logic [39:0] ex);
    int k;
    @(posedge clk);
    hold <= h;
    wrdy <= w;
    nb <= n;
    tx <= d;
    req <= 1'b1;
    msk_q.push_back(mk);
    exp_q.push_back(ex);
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k == 20000 || to !== 1'b0) begin
      errors++;
      stop_test();
    end
    req <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] s, input logic [23:0] v);
    xfer(1'b0, 1'b0, 6'h20, {8'h00, 2'b00, s, 3'b000, v}, '0, '0);
  endtask
  task automatic rd(input logic h, input logic w, input logic [2:0] s,
      input logic [5:0] n, input logic [39:0] mk, input logic [39:0] ex);
    xfer(h, w, n, 40'({2'b01, s, 3'b000}) << (n - 6'h08), mk, ex);
  endtask
  task automatic fall(output int n);
    n = 0;
    while (dw !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    while (dw !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) begin
      errors++;
      stop_test();
    end
  endtask

  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(posedge clk) begin
    done_q <= done;
    ch_prev <= conv_channel;
    if (done && !done_q) begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      if (m != '0) check(rx & m, e);
    end
    if (seq_on && conv_channel !== ch_prev) begin
      check(40'(conv_channel), 40'(nxt(mask, ch_prev)));
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    req = 1'b0;
    hold = 1'b0;
    wrdy = 1'b0;
    nb = '0;
    tx = '0;
    seq_on = 1'b0;
    mask = '0;
    md_t = '{24'h000040, 24'h000840, 24'h000840, 24'h000040};
    cf_t = '{24'h000100, 24'h000100, 24'h000600, 24'h000600};
    per_t = '{256, 1024, 1024, 1024};
    void'($urandom(32652));
    fr = DATA_W'($urandom);
    repeat (3) @(posedge clk);
    check({powered_up, conv_channel, dout_rdy_oe, dout_rdy}, 40'h21);
    rstn <= 1'b1;
    rd(1'b0, 1'b0, REG_CONFIG, 6'h20, 40'hFFFFFF, 40'(CONFIG_RST));
    wr(REG_CONFIG, 24'h000400);
    wr(REG_MODE, 24'h100840);
    rd(1'b0, 1'b0, REG_MODE, 6'h20, 40'hFFFFFF, 40'h100840);
    $display("register test ended");
    f0 = fr;
    rd(1'b1, 1'b1, REG_DATA, 6'h28, 40'hFFFFFFFF7F, {f0, 8'h02});
    repeat (6) @(posedge clk);
    check(dw, 1'b1);
    fr <= DATA_W'($urandom);
    rd(1'b1, 1'b0, REG_DATA, 6'h28, 40'hFFFFFFFF7F, {8'hFF, f0, 8'h02});
    $display("data read test ended");
    for (i = 0; i < 4; i++) begin
      wr(REG_CONFIG, cf_t[i]);
      wr(REG_MODE, md_t[i]);
      xfer(1'b1, 1'b0, 6'h00, '0, '0, '0);
      mask <= cf_t[i][CH_HI:CH_LO];
      seq_on <= 1'b1;
      fall(c);
      fall(c);
      fall(c);
      check(40'(c >= per_t[i] - 2 && c <= per_t[i] + 2), 40'h1);
      seq_on <= 1'b0;
      $display("interval test %0d ended", i);
    end
    wr(REG_MODE, 24'h200040);
    c = 0;
    while (powered_up !== 1'b0 && c < 4000) begin
      @(posedge clk);
      c++;
    end
    check(powered_up, 1'b0);
    rd(1'b0, 1'b0, REG_MODE, 6'h20, 40'hFFFFFF, 40'h600040);
    rd(1'b1, 1'b0, REG_DATA, 6'h20, 40'hFFFFFF, 40'(fr));
    repeat (100) @(posedge clk);
    check(dw, 1'b1);
    rd(1'b1, 1'b0, REG_STATUS, 6'h10, 40'hFF, 40'h82);
    wr(REG_MODE, 24'h200040);
    c = 0;
    while (mod_reset !== 1'b1 && c < 200) begin
      @(posedge clk);
      c++;
    end
    check(40'(c >= 14 && c <= 26), 40'h1);
    $display("single conversion test ended");
    xfer(1'b0, 1'b0, 6'h27, 40'hFFFFFFFFFF, '0, '0);
    rd(1'b0, 1'b0, REG_CONFIG, 6'h20, 40'hFFFFFF, 40'h000600);
    xfer(1'b0, 1'b0, 6'h28, 40'hFFFFFFFFFF, '0, '0);
    repeat (12500) @(posedge clk);
    rd(1'b0, 1'b0, REG_CONFIG, 6'h20, 40'hFFFFFF, 40'(CONFIG_RST));
    rd(1'b0, 1'b0, REG_MODE, 6'h20, 40'hFFFFFF, 40'(MODE_RST));
    repeat (4) @(posedge clk);
    $display("soft reset test ended");
    stop_test();
  end
endmodule
